// ===== logic/fault_mask_retry.sv
// Fault power-down masking and retry counter with its register port
//
// Behaviour
// [RULE_01] Reset-comparator fault forces power-down only while its mask is 0.
// [RULE_02] Any load-switch undervoltage flag forces power-down while mask is 0.
// [RULE_03] Linear regulator undervoltage forces power-down while its mask is 0.
// [RULE_04] Input overcurrent forces power-down while its mask is 0.
// [RULE_05] Low external-regulator power-good forces power-down while mask is 0.
// [RULE_06] Software writes zero to unused mask bits, ignores their read value.
// [RULE_07] Retry limit zero: a fault leaves the device off, no restart.
// [RULE_08] Nonzero limit: fault bumps retry count, then power-down runs to off.
// [RULE_09] Off with count below limit: restart automatically.
// [RULE_10] Off with count equal to limit: stay off.
// [RULE_11] Exhausted device recovers by power cycle or writing the clear bit.
// [RULE_12] Writing 1 to the clear bit clears the exhausted status.
// [RULE_13] The clear bit always reads zero.
// [RULE_14] Exhausted status reads 1 once count reached limit, else 0. The code reads 0 whenever the limit is zero.
// [RULE_15] Global enable bit turns retry counting off at 0, on at 1.
// [RULE_16] Power-down request is the OR of all unmasked fault sources.
`default_nettype none
module fault_mask_retry #(
  parameter logic [6:0] DEV_ADDR = fault_retry_pkg::I2C_DEV_ADDR
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial register port
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Fault sources
  input wire fault_retry_pkg::fault_s faults,
  // On/off controller
  input wire logic off_state,
  output logic power_down_req,
  output logic auto_restart
);
  localparam int W = fault_retry_pkg::LIM_W;

  fault_retry_pkg::reg_wr_s wr;
  logic [7:0] rd_addr, rd_data;
  logic [7:0] mask_r, mask_nxt;
  logic [W-1:0] lim_r, lim_nxt;
  logic [W-1:0] count_r, count_nxt;
  logic en_r, en_nxt;
  logic pd_r, pd_nxt;
  logic ar_r, ar_nxt;
  fault_retry_pkg::seq_e seq_r, seq_nxt;
  logic fault_any, counting, can_restart;
  logic exhausted, bump, clr;

  function automatic logic hit(input fault_retry_pkg::reg_wr_s w,
                               input logic [7:0] ofs);
    hit = w.valid && (w.addr == ofs);
  endfunction

  i2c_reg_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  always_comb begin
    fault_any = 1'b0;
    // [RULE_01] reset comparator mask
    if (!mask_r[fault_retry_pkg::MASK_RSTCMP_BIT] && faults.rst_cmp) begin
      fault_any = 1'b1;
    end
    // [RULE_02] load switch mask
    if (!mask_r[fault_retry_pkg::MASK_LSW_BIT] &&
        (faults.lsw1_uv || faults.lsw2_uv || faults.lsw3_uv)) begin
      fault_any = 1'b1;
    end
    // [RULE_03] linear regulator mask
    if (!mask_r[fault_retry_pkg::MASK_LDO_BIT] && faults.ldo_uv) begin
      fault_any = 1'b1;
    end
    // [RULE_04] overcurrent mask
    if (!mask_r[fault_retry_pkg::MASK_OC_BIT] && faults.in_oc) begin
      fault_any = 1'b1;
    end
    // Power-good is active high, so its low level is the fault
    // [RULE_05] external regulator mask
    if (!mask_r[fault_retry_pkg::MASK_EREG_BIT] && !faults.ereg_ok) begin
      fault_any = 1'b1;
    end
  end

  // Limit zero or enable low freezes the count and blocks restarts
  // [RULE_15] global enable gate
  assign counting = en_r && (lim_r != '0);
  // A nonzero limit lowered below the count reads as exhausted at once
  // [RULE_14] exhausted status
  assign exhausted = (lim_r != '0) && (count_r >= lim_r);
  // [RULE_09] restart allowed below limit
  assign can_restart = counting && (count_r < lim_r);
  // [RULE_12] clear by write of 1
  assign clr = hit(wr, fault_retry_pkg::RETRY_CFG_OFS) &&
               wr.data[fault_retry_pkg::CFG_CLR_BIT];
  // [RULE_08] one count per power-down cycle
  assign bump = (seq_r == fault_retry_pkg::SEQ_ON) && fault_any &&
                can_restart;

  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      fault_retry_pkg::MASK_OFS: begin
        // Unused upper bits simply store what was written
        rd_data = mask_r;
      end
      fault_retry_pkg::RETRY_CFG_OFS: begin
        rd_data[fault_retry_pkg::CFG_LIM_LSB +: W] = lim_r;
        // [RULE_13] clear bit reads zero
        rd_data[fault_retry_pkg::CFG_CLR_BIT] = 1'b0;
        rd_data[fault_retry_pkg::CFG_EXH_BIT] = exhausted;
      end
      fault_retry_pkg::RETRY_EN_OFS: begin
        rd_data[fault_retry_pkg::EN_BIT] = en_r;
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  always_comb begin
    mask_nxt = mask_r;
    lim_nxt = lim_r;
    en_nxt = en_r;
    if (hit(wr, fault_retry_pkg::MASK_OFS)) begin
      mask_nxt = wr.data;
    end
    if (hit(wr, fault_retry_pkg::RETRY_CFG_OFS)) begin
      lim_nxt = wr.data[7:fault_retry_pkg::CFG_LIM_LSB];
    end
    if (hit(wr, fault_retry_pkg::RETRY_EN_OFS)) begin
      en_nxt = wr.data[fault_retry_pkg::EN_BIT];
    end
  end

  // Sequence timing belongs to the on/off controller; this only tracks it
  always_comb begin
    seq_nxt = seq_r;
    count_nxt = count_r;
    // [RULE_11] software clear path
    if (clr) begin
      count_nxt = '0;
    end
    // An increment in the clear cycle still counts
    if (bump) begin
      count_nxt = (clr ? '0 : count_r) + {{(W-1){1'b0}}, 1'b1};
    end
    case (seq_r)
      fault_retry_pkg::SEQ_ON: begin
        // [RULE_07] enter power-down, count or not
        if (fault_any) begin
          seq_nxt = fault_retry_pkg::SEQ_DOWN;
        end
      end
      fault_retry_pkg::SEQ_DOWN: begin
        if (off_state) begin
          seq_nxt = fault_retry_pkg::SEQ_OFF;
        end
      end
      fault_retry_pkg::SEQ_OFF: begin
        if (!off_state) begin
          seq_nxt = fault_retry_pkg::SEQ_ON;
        end
      end
      default: begin
        seq_nxt = fault_retry_pkg::SEQ_ON;
      end
    endcase
    // [RULE_16] OR of unmasked faults
    pd_nxt = fault_any;
    // [RULE_10] no restart once limit is met
    ar_nxt = (seq_r == fault_retry_pkg::SEQ_OFF) && off_state &&
             can_restart;
  end

  // Both controller outputs come straight from flops, free of glitches
  assign power_down_req = pd_r;
  assign auto_restart = ar_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= fault_retry_pkg::MASK_RST;
      lim_r <= fault_retry_pkg::RETRY_CFG_RST[7:fault_retry_pkg::CFG_LIM_LSB];
      en_r <= fault_retry_pkg::RETRY_EN_RST[fault_retry_pkg::EN_BIT];
    end else begin
      mask_r <= mask_nxt;
      lim_r <= lim_nxt;
      en_r <= en_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
      seq_r <= fault_retry_pkg::SEQ_ON;
      pd_r <= 1'b0;
      ar_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      seq_r <= seq_nxt;
      pd_r <= pd_nxt;
      ar_r <= ar_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== logic/fault_retry_pkg.sv
// Shared constants and types for the fault mask and retry block
`default_nettype none
package fault_retry_pkg;
  localparam logic [6:0] I2C_DEV_ADDR = 7'h60;
  localparam logic [7:0] MASK_OFS = 8'h06;
  localparam logic [7:0] RETRY_CFG_OFS = 8'h28;
  localparam logic [7:0] RETRY_EN_OFS = 8'h19;
  localparam logic [7:0] MASK_RST = 8'h02;
  localparam logic [7:0] RETRY_CFG_RST = 8'h1C;
  localparam logic [7:0] RETRY_EN_RST = 8'h80;
  localparam int MASK_RSTCMP_BIT = 4;
  localparam int MASK_LSW_BIT = 3;
  localparam int MASK_LDO_BIT = 2;
  localparam int MASK_OC_BIT = 1;
  localparam int MASK_EREG_BIT = 0;
  localparam int LIM_W = 6;
  localparam int CFG_LIM_LSB = 2;
  localparam int CFG_CLR_BIT = 1;
  localparam int CFG_EXH_BIT = 0;
  localparam int EN_BIT = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_s;

  typedef struct packed {
    logic rst_cmp;
    logic lsw1_uv;
    logic lsw2_uv;
    logic lsw3_uv;
    logic ldo_uv;
    logic in_oc;
    logic ereg_ok;
  } fault_s;

  typedef enum logic [2:0] {
    SEQ_ON = 3'b001,
    SEQ_DOWN = 3'b010,
    SEQ_OFF = 3'b100
  } seq_e;

  typedef enum logic [4:0] {
    I2C_IDLE = 5'b00001,
    I2C_RECV = 5'b00010,
    I2C_ACK = 5'b00100,
    I2C_SEND = 5'b01000,
    I2C_RACK = 5'b10000
  } i2c_e;
endpackage
`default_nettype wire

// ===== logic/i2c_reg_port.sv
// Serial register port: byte framing, pointer and open-drain data line
`default_nettype none
module i2c_reg_port #(
  parameter logic [6:0] DEV_ADDR = fault_retry_pkg::I2C_DEV_ADDR
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Register side
  output fault_retry_pkg::reg_wr_s wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  fault_retry_pkg::i2c_e st_r, st_nxt;
  logic scl_q_r, scl_q_nxt, sda_q_r, sda_q_nxt;
  logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [1:0] idx_r, idx_nxt;
  logic rw_r, rw_nxt, oe_n_r, oe_n_nxt;
  fault_retry_pkg::reg_wr_s wr_r, wr_nxt;
  logic rise, fall, start, stop;

  assign rise = scl_in & ~scl_q_r;
  assign fall = ~scl_in & scl_q_r;
  assign start = scl_in & scl_q_r & sda_q_r & ~sda_in;
  assign stop = scl_in & scl_q_r & ~sda_q_r & sda_in;
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_r;
  assign wr = wr_r;
  assign rd_addr = ptr_r;

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    rw_nxt = rw_r;
    oe_n_nxt = oe_n_r;
    wr_nxt = '0;
    scl_q_nxt = scl_in;
    sda_q_nxt = sda_in;
    if (stop) begin
      st_nxt = fault_retry_pkg::I2C_IDLE;
      oe_n_nxt = 1'b1;
    end else if (start) begin
      // Repeated start keeps the pointer for a read-back
      st_nxt = fault_retry_pkg::I2C_RECV;
      cnt_nxt = 4'h0;
      idx_nxt = 2'h0;
      oe_n_nxt = 1'b1;
    end else begin
      case (st_r)
        fault_retry_pkg::I2C_IDLE: begin
          oe_n_nxt = 1'b1;
        end
        fault_retry_pkg::I2C_RECV: begin
          if (rise) begin
            sh_nxt = {sh_r[6:0], sda_in};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == fault_retry_pkg::BITS_PER_BYTE) begin
            cnt_nxt = 4'h0;
            st_nxt = fault_retry_pkg::I2C_ACK;
            oe_n_nxt = 1'b0;
            if (idx_r == 2'h0) begin
              rw_nxt = sh_r[0];
              idx_nxt = 2'h1;
              if (sh_r[7:1] != DEV_ADDR) begin
                st_nxt = fault_retry_pkg::I2C_IDLE;
                oe_n_nxt = 1'b1;
              end
            end else if (idx_r == 2'h1) begin
              ptr_nxt = sh_r;
              idx_nxt = 2'h2;
            end else begin
              wr_nxt.valid = 1'b1;
              wr_nxt.addr = ptr_r;
              wr_nxt.data = sh_r;
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        fault_retry_pkg::I2C_ACK: begin
          if (fall) begin
            if (rw_r) begin
              sh_nxt = rd_data;
              oe_n_nxt = rd_data[7];
              st_nxt = fault_retry_pkg::I2C_SEND;
            end else begin
              oe_n_nxt = 1'b1;
              st_nxt = fault_retry_pkg::I2C_RECV;
            end
          end
        end
        fault_retry_pkg::I2C_SEND: begin
          if (fall) begin
            sh_nxt = {sh_r[6:0], 1'b0};
            cnt_nxt = cnt_r + 4'h1;
            oe_n_nxt = sh_r[6];
            if (cnt_r == 4'h7) begin
              cnt_nxt = 4'h0;
              oe_n_nxt = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
              st_nxt = fault_retry_pkg::I2C_RACK;
            end
          end
        end
        fault_retry_pkg::I2C_RACK: begin
          // Master NACK ends the read
          if (rise && sda_in) begin
            st_nxt = fault_retry_pkg::I2C_IDLE;
          end else if (fall) begin
            sh_nxt = rd_data;
            oe_n_nxt = rd_data[7];
            st_nxt = fault_retry_pkg::I2C_SEND;
          end
        end
        default: begin
          st_nxt = fault_retry_pkg::I2C_IDLE;
          oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= fault_retry_pkg::I2C_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      cnt_r <= 4'h0;
      idx_r <= 2'h0;
      rw_r <= 1'b0;
      oe_n_r <= 1'b1;
      wr_r <= '0;
    end else begin
      st_r <= st_nxt;
      scl_q_r <= scl_q_nxt;
      sda_q_r <= sda_q_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      rw_r <= rw_nxt;
      oe_n_r <= oe_n_nxt;
      wr_r <= wr_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== bench/fault_mask_retry_assertions.sv
// Port-level assertions for the fault mask and retry block
`default_nettype none
module fault_mask_retry_assertions (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Faults and on/off controller
  input wire fault_retry_pkg::fault_s faults,
  input wire logic off_state,
  input wire logic power_down_req,
  input wire logic auto_restart
);
  timeunit 1ns;
  timeprecision 1ns;
  // Any raw fault, masks ignored
  wire logic raw_fault = (faults != 7'h01);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Masks move only through bus traffic, so a long scl high is calm
  sequence s_calm_faults;
    (scl_in && $stable(faults)) [*5];
  endsequence
  sequence s_calm_off;
    (scl_in && $stable(off_state)) [*5];
  endsequence
  property p_pdr_cause;
    power_down_req |-> $past(raw_fault);
  endproperty
  a_pdr_cause: assert property (p_pdr_cause)
    else $error("power-down request with no fault");
  property p_pdr_hold;
    s_calm_faults |=> $stable(power_down_req);
  endproperty
  a_pdr_hold: assert property (p_pdr_hold)
    else $error("power-down request moved while calm");
  property p_restart_on;
    !off_state |=> !auto_restart;
  endproperty
  a_restart_on: assert property (p_restart_on)
    else $error("restart outside off state");
  property p_restart_rise;
    $rose(auto_restart) |-> $past(off_state) && $past(off_state, 2);
  endproperty
  a_restart_rise: assert property (p_restart_rise)
    else $error("restart rose too early");
  property p_restart_hold;
    s_calm_off |=> $stable(auto_restart);
  endproperty
  a_restart_hold: assert property (p_restart_hold)
    else $error("restart moved while calm");
  // Pulling data while scl is high would fake a start or stop
  property p_oe_scl_low;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data enable moved with scl high");
  property p_od_low;
    sda_out == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain data not low");
  property p_reset_idle;
    !$past(rst_n) |-> sda_oe_n && !auto_restart && !power_down_req;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs not idle after reset");
endmodule
bind fault_mask_retry fault_mask_retry_assertions chk_u (
  .sys_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe_n, .faults,
  .off_state, .power_down_req, .auto_restart
);
`default_nettype wire

// ===== bench/i2c_host_model.sv
// Host processor model on the serial register port
`default_nettype none
module i2c_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  output logic scl,
  output logic sda_lo,
  input wire logic sda,
  // Sticky missing acknowledge
  output logic nak
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
    nak = 1'b0;
  end
  // Four cycles a phase leaves room for the port's edge detection
  task automatic ph();
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_lo = !b;
    ph();
    scl = 1'b1;
    ph();
    r = sda;
    scl = 1'b0;
    ph();
  endtask
  task automatic byx(input logic [7:0] d, input logic ab,
                     output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(ab, a);
  endtask
  // Serves as start and repeated start
  task automatic start();
    sda_lo = 1'b0;
    ph();
    scl = 1'b1;
    ph();
    sda_lo = 1'b1;
    ph();
    scl = 1'b0;
    ph();
  endtask
  task automatic stop();
    sda_lo = 1'b1;
    ph();
    scl = 1'b1;
    ph();
    sda_lo = 1'b0;
    ph();
  endtask
  // Address phase only, to see a foreign device address refused
  task automatic probe(input logic [6:0] dev, output logic a);
    logic [7:0] r;
    start();
    byx({dev, 1'b0}, 1'b1, r, a);
    stop();
  endtask
  task automatic wb(input logic [7:0] d);
    logic [7:0] r;
    logic a;
    byx(d, 1'b1, r, a);
    nak = nak | a;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    start();
    wb({fault_retry_pkg::I2C_DEV_ADDR, 1'b0});
    wb(ofs);
    wb(v);
    stop();
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] v);
    logic a;
    start();
    wb({fault_retry_pkg::I2C_DEV_ADDR, 1'b0});
    wb(ofs);
    start();
    wb({fault_retry_pkg::I2C_DEV_ADDR, 1'b1});
    byx(8'hFF, 1'b1, v, a);
    stop();
  endtask
endmodule
`default_nettype wire

// ===== bench/fault_mask_retry_tb.sv
// Self-checking bench for the fault mask and retry block
`default_nettype none
module fault_mask_retry_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic off_state = 1'b0;
  fault_retry_pkg::fault_s faults = 7'h01;
  logic scl_in, host_lo, nak, sda_out, sda_oe_n;
  logic power_down_req, auto_restart;
  // Pull-up on the shared data line
  wire logic sda_in = !host_lo && (sda_oe_n || sda_out);
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];
  logic [7:0] got, e;
  event got_ev;
  always #50 sys_clk = ~sys_clk;
  fault_mask_retry dut_u (.sys_clk, .rst_n, .scl_in, .sda_in, .sda_out,
    .sda_oe_n, .faults, .off_state, .power_down_req, .auto_restart);
  i2c_host_model host_u (.sys_clk, .scl(scl_in), .sda_lo(host_lo),
    .sda(sda_in), .nak);
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end
  always @(got_ev) begin
    e = exp_q.pop_front();
    num_checks++;
    if (got !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, e);
    end
  end
  task automatic note(input logic [7:0] x, input logic [7:0] v);
    exp_q.push_back(x);
    got = v;
    -> got_ev;
    @(negedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] r;
    host_u.rd(a, r);
    note(x, r);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // One fault, off state, then the on/off controller turns back on
  task automatic hiccup(input logic [6:0] f, input logic x);
    faults = f;
    idle(3);
    faults = 7'h01;
    off_state = 1'b1;
    idle(3);
    note({7'h00, x}, {7'h00, auto_restart});
    off_state = 1'b0;
    idle(3);
  endtask
  function automatic int mbit(input int k);
    return (k == 0) ? 4 : (k < 4) ? 3 : 6 - k;
  endfunction
  initial begin
    logic [7:0] m;
    logic [6:0] f;
    logic a;
    void'($urandom(99));
    idle(8);
    rst_n = 1'b1;
    idle(1);
    chk(fault_retry_pkg::MASK_OFS, 8'h02);
    chk(fault_retry_pkg::RETRY_CFG_OFS, 8'h1C);
    chk(fault_retry_pkg::RETRY_EN_OFS, 8'h80);
    chk(8'h30, 8'h00);
    host_u.probe(fault_retry_pkg::I2C_DEV_ADDR ^ 7'h01, a);
    note(8'h01, {7'h00, a});
    chk(fault_retry_pkg::MASK_OFS, 8'h02);
    $display("test reset_values done");
    for (int k = 0; k < 7; k++) begin
      m = 8'($urandom()) & 8'h1F & ~(8'h01 << mbit(k));
      host_u.wr(fault_retry_pkg::MASK_OFS, m);
      faults = 7'h01 ^ (7'h40 >> k);
      idle(3);
      note(8'h01, {7'h00, power_down_req});
      m = m | (8'h01 << mbit(k));
      host_u.wr(fault_retry_pkg::MASK_OFS, m);
      idle(3);
      note(8'h00, {7'h00, power_down_req});
      chk(fault_retry_pkg::MASK_OFS, m);
      faults = 7'h01;
    end
    $display("test masks done");
    f = 7'h01 ^ (7'h40 >> ($urandom() % 7));
    host_u.wr(fault_retry_pkg::MASK_OFS, 8'h00);
    host_u.wr(fault_retry_pkg::RETRY_CFG_OFS, 8'h0A);
    chk(fault_retry_pkg::RETRY_CFG_OFS, 8'h08);
    hiccup(7'h01, 1'b1);
    hiccup(f, 1'b1);
    hiccup(f, 1'b0);
    chk(fault_retry_pkg::RETRY_CFG_OFS, 8'h09);
    host_u.wr(fault_retry_pkg::RETRY_CFG_OFS, 8'h0A);
    chk(fault_retry_pkg::RETRY_CFG_OFS, 8'h08);
    hiccup(f, 1'b1);
    $display("test retry done");
    host_u.wr(fault_retry_pkg::RETRY_CFG_OFS, 8'h00);
    hiccup(f, 1'b0);
    chk(fault_retry_pkg::RETRY_CFG_OFS, 8'h00);
    host_u.wr(fault_retry_pkg::RETRY_CFG_OFS, 8'h0A);
    host_u.wr(fault_retry_pkg::RETRY_EN_OFS, 8'h00);
    hiccup(f, 1'b0);
    chk(fault_retry_pkg::RETRY_EN_OFS, 8'h00);
    host_u.wr(fault_retry_pkg::RETRY_EN_OFS, 8'h80);
    hiccup(f, 1'b1);
    note(8'h00, {7'h00, nak});
    $display("test limit_and_enable done");
    hiccup(f, 1'b0);
    // A mid-run reset stands in for a power cycle
    rst_n = 1'b0;
    idle(8);
    rst_n = 1'b1;
    idle(1);
    chk(fault_retry_pkg::RETRY_CFG_OFS, 8'h1C);
    chk(fault_retry_pkg::MASK_OFS, 8'h02);
    host_u.wr(fault_retry_pkg::MASK_OFS, 8'h00);
    hiccup(f, 1'b1);
    note(8'h00, {7'h00, nak});
    $display("test power_cycle done");
    report_and_stop();
  end
endmodule
`default_nettype wire
